// ### design/aea_active_energy.sv
// active energy accumulator with sign, no-load and energy event flags
//
// Overview of operation
// [R1] flag power sign change in status low
// [R2] mode bit clear: flag positive-to-negative only
// [R3] mode bit set: flag negative-to-positive only
// [R4] enabled sign flag holds interrupt until cleared
// [R5] no accumulation below no-load threshold
// [R6] no-load flag set; enabled, holds interrupt
// [R7] two-bit threshold code: off or three levels
// [R8] signed 49-bit accumulator, upper 24 readable
// [R9] one sample added every 5 clocks
// [R10] both mode bits clear: signed accumulation
// [R11] both bits set: positive-only wins
// [R12] absolute bit alone: accumulate magnitude
// [R13] positive-only: negative samples ignored
// [R14] detectors stay live; positive-only off at reset
// [R15] divide by 8-bit divider, zero means one
// [R16] read-clear read returns value, clears upper bits
// [R17] power waveform samples at four selectable rates
// [R18] energy value wraps around both ends
// [R19] half-full and overflow/underflow event flags
// [R20] signed mode after reset
// [R21] gain of one plus gain over 4096
// [R22] signed offset, 256 counts per sample LSB
// [R23] interrupt is OR of set enabled flags
// [R24] detectors use same samples, once per period
// [R25] software reads often enough to catch wraps
`timescale 1ns/1ps
`default_nettype none
module aea_active_energy
    import aea_pkg::*;
#(
    parameter int PW = 24,
    parameter int WAV_BASE_CYC = WAV_BASE_CYC_DEF
) (
    // clock, reset, enable
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // filtered active power
    input wire logic signed [PW-1:0] i_power,
    // register port
    input wire aea_req_s i_req,
    output logic [23:0] o_reg_rdata,
    // interrupt and waveform
    output logic o_irq,
    output logic [23:0] o_wave_data,
    output logic o_wave_valid
);
    aea_state_s st_q;
    aea_state_s st_d;

    function automatic logic signed [47:0] abs48(input logic signed [47:0] v);
        abs48 = v[47] ? -v : v;
    endfunction : abs48

    function automatic logic signed [47:0] nl_thr(input logic [1:0] code);
        case (code)
            2'h1: nl_thr = PWR_FS * PPM_1 / PPM_DEN;
            2'h2: nl_thr = PWR_FS * PPM_2 / PPM_DEN;
            default: nl_thr = PWR_FS * PPM_3 / PPM_DEN;
        endcase
    endfunction : nl_thr

    function automatic logic [23:0] reg_read(input aea_state_s s, input logic [7:0] a);
        if (a == ADDR_WAV_SEL) reg_read = {16'h0000, s.wav_sel};
        else if (a == ADDR_NL_CFG) reg_read = {16'h0000, s.nl_cfg};
        else if (a == ADDR_ACC_CFG) reg_read = {16'h0000, s.acc_cfg};
        else if (a == ADDR_EN_LO) reg_read = {16'h0000, s.en_lo};
        else if (a == ADDR_EN_HI) reg_read = {16'h0000, s.en_hi};
        else if (a == ADDR_STS_LO) reg_read = {16'h0000, s.sts_lo};
        else if (a == ADDR_DIV) reg_read = {16'h0000, s.div};
        else if (a == ADDR_GAIN) reg_read = {12'h000, s.gain};
        else if (a == ADDR_OFS) reg_read = {8'h00, s.ofs};
        else if (a == ADDR_ENERGY || a == ADDR_ENERGY_RC) reg_read = s.acc[48:25];
        else reg_read = 24'h000000;
    endfunction : reg_read

    logic tick;
    logic signed [47:0] fine;
    logic signed [47:0] gained;
    logic signed [47:0] divisor;
    logic signed [47:0] scaled;
    logic signed [47:0] addend;
    logic [48:0] base;
    logic [48:0] acc_new;
    logic no_load;
    logic neg;
    logic add_en;
    logic rc_read;
    logic wav_fire;
    logic [7:0] set_lo;
    logic [7:0] clr_lo;
    logic [1:0] ot;
    logic [1:0] nt;

    always_comb begin
        st_d = st_q;
        tick = i_ce && (st_q.phase == 3'(ACC_PERIOD_CYC - 1)); // see [R9]
        // offset in fine units then gain, sample LSB is 256 fine counts
        fine = (48'(i_power) <<< OFS_SHIFT) + 48'(signed'(st_q.ofs)); // see [R22]
        gained = (fine * 48'(GAIN_ONE + 14'(signed'(st_q.gain)))) >>> GAIN_SHIFT; // see [R21]
        divisor = (st_q.div == 8'h00) ? 48'sh1 : 48'(st_q.div); // see [R15]
        scaled = gained / divisor;
        neg = gained[47];
        // no-load judged on multiplier output, before the divider
        no_load = (st_q.nl_cfg[1:0] != 2'h0) && (abs48(gained) < nl_thr(st_q.nl_cfg[1:0])); // see [R7]
        // positive-only checked first so it wins when both bits are set
        if (st_q.acc_cfg[ACC_POS_ONLY]) begin // see [R11]
            add_en = !neg; // see [R13]
            addend = scaled;
        end else if (st_q.acc_cfg[ACC_ABS]) begin
            add_en = 1'b1;
            addend = abs48(scaled); // see [R12]
        end else begin
            add_en = 1'b1;
            addend = scaled; // see [R10] [R20]
        end
        add_en = add_en && !no_load && tick; // see [R5]
        rc_read = i_ce && i_req.rd && (i_req.addr == ADDR_ENERGY_RC);
        base = rc_read ? {24'h000000, st_q.acc[24:0]} : st_q.acc; // see [R16]
        acc_new = add_en ? base + 49'(addend) : base; // see [R8] [R18]
        ot = base[48:47];
        nt = acc_new[48:47];
        set_lo = 8'h00;
        if (tick) begin // see [R24] [R14]
            set_lo[ST_NO_LOAD] = no_load; // see [R6]
            if (st_q.acc_cfg[ACC_SIGN_DIR])
                set_lo[ST_SIGN] = st_q.prev_neg && !neg; // see [R3]
            else
                set_lo[ST_SIGN] = !st_q.prev_neg && neg; // see [R1] [R2]
        end
        if (add_en) begin // see [R19]
            set_lo[ST_HALF_POS] = (ot == 2'h0) && (nt == 2'h1);
            set_lo[ST_HALF_NEG] = (ot == 2'h3) && (nt == 2'h2);
            set_lo[ST_OVF] = !ot[1] && nt[1] && !addend[47];
            set_lo[ST_UNF] = ot[1] && !nt[1] && addend[47];
        end
        clr_lo = 8'h00;
        if (i_ce && i_req.wr && i_req.addr == ADDR_STS_LO) clr_lo = i_req.wdata[7:0];
        wav_fire = i_ce && (st_q.wav_cnt == 16'h0000);
        if (i_ce) begin
            st_d.phase = tick ? 3'h0 : st_q.phase + 3'h1;
            st_d.acc = acc_new;
            if (tick) st_d.prev_neg = neg;
            // write-one-to-clear; a new event in the same cycle wins
            st_d.sts_lo = (st_q.sts_lo & ~clr_lo) | set_lo;
            if (i_req.wr) begin
                if (i_req.addr == ADDR_WAV_SEL) st_d.wav_sel = i_req.wdata[7:0];
                else if (i_req.addr == ADDR_NL_CFG) st_d.nl_cfg = i_req.wdata[7:0];
                else if (i_req.addr == ADDR_ACC_CFG) st_d.acc_cfg = i_req.wdata[7:0];
                else if (i_req.addr == ADDR_EN_LO) st_d.en_lo = i_req.wdata[7:0];
                else if (i_req.addr == ADDR_EN_HI) st_d.en_hi = i_req.wdata[7:0];
                else if (i_req.addr == ADDR_DIV) st_d.div = i_req.wdata[7:0];
                else if (i_req.addr == ADDR_GAIN) st_d.gain = i_req.wdata[11:0];
                else if (i_req.addr == ADDR_OFS) st_d.ofs = i_req.wdata[15:0];
            end
            if (i_req.rd) st_d.rdata = reg_read(st_q, i_req.addr);
            st_d.irq = |(st_d.sts_lo & st_d.en_lo); // see [R4] [R23]
            // rate code doubles the period per step
            st_d.wav_cnt = wav_fire
                ? 16'((WAV_BASE_CYC << st_q.wav_sel[WAV_RATE_LSB +: 2]) - 1)
                : st_q.wav_cnt - 16'h0001;
            st_d.wav_valid = wav_fire && st_q.en_hi[EN_HI_WAVE]
                && (st_q.wav_sel[2:0] == WAV_SRC_POWER); // see [R17]
            if (wav_fire) st_d.wav_data = gained[OFS_SHIFT +: 24];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            st_q <= '0;
            st_q.wav_sel <= CFG_RST;
            st_q.nl_cfg <= CFG_RST;
            st_q.acc_cfg <= CFG_RST; // see [R14] [R20]
            st_q.div <= DIV_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_reg_rdata = st_q.rdata;
    assign o_irq = st_q.irq;
    assign o_wave_data = st_q.wav_data;
    assign o_wave_valid = st_q.wav_valid;

    sequence s_tick_add;
        tick && add_en && !rc_read;
    endsequence

    sequence s_tick_quiet;
        tick && !rc_read;
    endsequence

    property p_period;
        @(posedge i_mclk) disable iff (!i_rst_n) tick |=> !tick [*4];
    endproperty
    a_period: assert property (p_period) else $error("sample spacing below period"); // see [R9]

    property p_irq;
        @(posedge i_mclk) disable iff (!i_rst_n) o_irq == |(st_q.sts_lo & st_q.en_lo);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not OR of enabled flags"); // see [R23]

    property p_no_load;
        @(posedge i_mclk) disable iff (!i_rst_n)
            s_tick_quiet and no_load |=> st_q.acc == $past(st_q.acc)
            && st_q.sts_lo[ST_NO_LOAD];
    endproperty
    a_no_load: assert property (p_no_load) else $error("accumulated under no-load"); // see [R5]

    property p_sign_pn;
        @(posedge i_mclk) disable iff (!i_rst_n)
            tick && !st_q.acc_cfg[ACC_SIGN_DIR] && !st_q.prev_neg && neg
            |=> st_q.sts_lo[ST_SIGN];
    endproperty
    a_sign_pn: assert property (p_sign_pn) else $error("missed sign change"); // see [R2]

    property p_sign_np;
        @(posedge i_mclk) disable iff (!i_rst_n)
            tick && st_q.acc_cfg[ACC_SIGN_DIR] && !st_q.prev_neg && neg
            && !st_q.sts_lo[ST_SIGN] |=> !st_q.sts_lo[ST_SIGN];
    endproperty
    a_sign_np: assert property (p_sign_np) else $error("wrong sign direction"); // see [R3]

    property p_pos_only;
        @(posedge i_mclk) disable iff (!i_rst_n)
            s_tick_quiet and st_q.acc_cfg[ACC_POS_ONLY] && neg
            |=> st_q.acc == $past(st_q.acc);
    endproperty
    a_pos_only: assert property (p_pos_only) else $error("negative added"); // see [R13]

    property p_abs;
        @(posedge i_mclk) disable iff (!i_rst_n)
            s_tick_add and st_q.acc_cfg[ACC_ABS] && !st_q.acc_cfg[ACC_POS_ONLY]
            |=> st_q.acc == 49'($past(st_q.acc) + 49'(abs48($past(scaled))));
    endproperty
    a_abs: assert property (p_abs) else $error("absolute sum wrong"); // see [R12]

    property p_rc;
        @(posedge i_mclk) disable iff (!i_rst_n)
            rc_read && !add_en |=> st_q.acc[48:25] == 24'h000000
            ##1 o_reg_rdata == $past(st_q.acc[48:25], 2);
    endproperty
    a_rc: assert property (p_rc) else $error("read-clear failed"); // see [R16]

    property p_half_pos;
        @(posedge i_mclk) disable iff (!i_rst_n)
            add_en && base[48:47] == 2'h0 && acc_new[48:47] == 2'h1 |=> st_q.sts_lo[ST_HALF_POS];
    endproperty
    a_half_pos: assert property (p_half_pos) else $error("missed positive half-full"); // see [R19]

    property p_half_neg;
        @(posedge i_mclk) disable iff (!i_rst_n)
            add_en && base[48:47] == 2'h3 && acc_new[48:47] == 2'h2 |=> st_q.sts_lo[ST_HALF_NEG];
    endproperty
    a_half_neg: assert property (p_half_neg) else $error("missed negative half-full"); // see [R19]

    property p_ovf;
        @(posedge i_mclk) disable iff (!i_rst_n)
            add_en && !base[48] && acc_new[48] && !addend[47] |=> st_q.sts_lo[ST_OVF];
    endproperty
    a_ovf: assert property (p_ovf) else $error("missed overflow"); // see [R18]

    property p_unf;
        @(posedge i_mclk) disable iff (!i_rst_n)
            add_en && base[48] && !acc_new[48] && addend[47] |=> st_q.sts_lo[ST_UNF];
    endproperty
    a_unf: assert property (p_unf) else $error("missed underflow"); // see [R18]

    property p_signed;
        @(posedge i_mclk) disable iff (!i_rst_n)
            s_tick_add and st_q.acc_cfg[1:0] == 2'h0
            |=> st_q.acc == 49'($past(st_q.acc) + 49'($past(scaled)));
    endproperty
    a_signed: assert property (p_signed) else $error("signed sum wrong"); // see [R10]

    property p_pos_add;
        @(posedge i_mclk) disable iff (!i_rst_n)
            s_tick_add and st_q.acc_cfg[ACC_POS_ONLY]
            |=> st_q.acc == 49'($past(st_q.acc) + 49'($past(scaled)));
    endproperty
    a_pos_add: assert property (p_pos_add) else $error("positive-only sum wrong"); // see [R11]

    property p_abs_sign;
        @(posedge i_mclk) disable iff (!i_rst_n)
            tick && add_en && st_q.acc_cfg[ACC_ABS] |-> !addend[47];
    endproperty
    a_abs_sign: assert property (p_abs_sign) else $error("negative addend in abs mode"); // see [R12]

    property p_div_one;
        @(posedge i_mclk) disable iff (!i_rst_n)
            st_q.div == 8'h00 |-> scaled == gained;
    endproperty
    a_div_one: assert property (p_div_one) else $error("zero divider not one"); // see [R15]

    property p_nl_off;
        @(posedge i_mclk) disable iff (!i_rst_n)
            st_q.nl_cfg[1:0] == 2'h0 |-> !no_load;
    endproperty
    a_nl_off: assert property (p_nl_off) else $error("no-load active while off"); // see [R7]

    property p_nl_flag;
        @(posedge i_mclk) disable iff (!i_rst_n)
            tick && no_load |=> st_q.sts_lo[ST_NO_LOAD];
    endproperty
    a_nl_flag: assert property (p_nl_flag) else $error("no-load flag not set"); // see [R6]

    property p_nl_hold;
        @(posedge i_mclk) disable iff (!i_rst_n)
            st_q.sts_lo[ST_NO_LOAD] && !clr_lo[ST_NO_LOAD] |=> st_q.sts_lo[ST_NO_LOAD];
    endproperty
    a_nl_hold: assert property (p_nl_hold) else $error("no-load flag lost"); // see [R6]

    property p_sign_hold;
        @(posedge i_mclk) disable iff (!i_rst_n)
            st_q.sts_lo[ST_SIGN] && !clr_lo[ST_SIGN] |=> st_q.sts_lo[ST_SIGN];
    endproperty
    a_sign_hold: assert property (p_sign_hold) else $error("sign flag lost"); // see [R4]

    property p_sign_np_set;
        @(posedge i_mclk) disable iff (!i_rst_n)
            tick && st_q.acc_cfg[ACC_SIGN_DIR] && st_q.prev_neg && !neg |=> st_q.sts_lo[ST_SIGN];
    endproperty
    a_sign_np_set: assert property (p_sign_np_set) else $error("missed rising sign"); // see [R3]

    property p_sign_pn_quiet;
        @(posedge i_mclk) disable iff (!i_rst_n)
            tick && !st_q.acc_cfg[ACC_SIGN_DIR] && st_q.prev_neg && !neg
            && !st_q.sts_lo[ST_SIGN] |=> !st_q.sts_lo[ST_SIGN];
    endproperty
    a_sign_pn_quiet: assert property (p_sign_pn_quiet) else $error("flag on rising sign"); // see [R2]

    property p_prev_hold;
        @(posedge i_mclk) disable iff (!i_rst_n)
            !tick |=> st_q.prev_neg == $past(st_q.prev_neg);
    endproperty
    a_prev_hold: assert property (p_prev_hold) else $error("sign sampled off tick"); // see [R24]

    property p_pos_flags;
        @(posedge i_mclk) disable iff (!i_rst_n)
            tick && st_q.acc_cfg[ACC_POS_ONLY] && no_load |=> st_q.sts_lo[ST_NO_LOAD];
    endproperty
    a_pos_flags: assert property (p_pos_flags) else $error("detector idle in mode"); // see [R14]

    property p_wave_off;
        @(posedge i_mclk) disable iff (!i_rst_n)
            wav_fire && !st_q.en_hi[EN_HI_WAVE] |=> !o_wave_valid;
    endproperty
    a_wave_off: assert property (p_wave_off) else $error("sample while disabled"); // see [R17]

    property p_wave_on;
        @(posedge i_mclk) disable iff (!i_rst_n)
            wav_fire && st_q.en_hi[EN_HI_WAVE] && st_q.wav_sel[2:0] == WAV_SRC_POWER
            |=> o_wave_valid;
    endproperty
    a_wave_on: assert property (p_wave_on) else $error("missed power sample"); // see [R17]

    property p_wave_data;
        @(posedge i_mclk) disable iff (!i_rst_n)
            wav_fire |=> o_wave_data == $past(gained[OFS_SHIFT +: 24]);
    endproperty
    a_wave_data: assert property (p_wave_data) else $error("sample data wrong"); // see [R22]

    property p_energy_rd;
        @(posedge i_mclk) disable iff (!i_rst_n)
            i_ce && i_req.rd && i_req.addr == ADDR_ENERGY |=> o_reg_rdata == $past(st_q.acc[48:25]);
    endproperty
    a_energy_rd: assert property (p_energy_rd) else $error("energy read wrong"); // see [R8]

    property p_rc_data;
        @(posedge i_mclk) disable iff (!i_rst_n)
            rc_read |=> o_reg_rdata == $past(st_q.acc[48:25]);
    endproperty
    a_rc_data: assert property (p_rc_data) else $error("read-clear data wrong"); // see [R16]

    property p_freeze;
        @(posedge i_mclk) disable iff (!i_rst_n)
            !i_ce |=> st_q == $past(st_q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while disabled");

    // reset is not a disable here: the check is about what reset leaves behind
    property p_reset_cfg;
        @(posedge i_mclk)
            !i_rst_n |=> st_q.acc_cfg == CFG_RST && st_q.nl_cfg == CFG_RST;
    endproperty
    a_reset_cfg: assert property (p_reset_cfg) else $error("mode not default"); // see [R20]
endmodule : aea_active_energy
`default_nettype wire

// ### design/aea_pkg.sv
// constants, register map and types of the active energy accumulator
package aea_pkg;
    // timing
    localparam int CLK_HZ = 32'h0262_5a00;
    localparam int ACC_PERIOD_CYC = 32'h5;
    localparam int WAV_RATE_HZ = 32'h6cfc;
    localparam int WAV_BASE_CYC_DEF = CLK_HZ / WAV_RATE_HZ;
    // widths
    localparam int ACC_W = 32'h31;
    localparam int E_W = 32'h18;
    localparam int WIDE_W = 32'h30;
    // register addresses
    localparam logic [7:0] ADDR_WAV_SEL = 8'h0d;
    localparam logic [7:0] ADDR_NL_CFG = 8'h0e;
    localparam logic [7:0] ADDR_ACC_CFG = 8'h0f;
    localparam logic [7:0] ADDR_EN_LO = 8'hd9;
    localparam logic [7:0] ADDR_EN_HI = 8'hdb;
    localparam logic [7:0] ADDR_STS_LO = 8'hdc;
    localparam logic [7:0] ADDR_DIV = 8'h10;
    localparam logic [7:0] ADDR_GAIN = 8'h11;
    localparam logic [7:0] ADDR_OFS = 8'h12;
    localparam logic [7:0] ADDR_ENERGY = 8'h1e;
    localparam logic [7:0] ADDR_ENERGY_RC = 8'h1f;
    // field positions
    localparam int ACC_POS_ONLY = 32'h0;
    localparam int ACC_ABS = 32'h1;
    localparam int ACC_SIGN_DIR = 32'h2;
    localparam int ST_NO_LOAD = 32'h0;
    localparam int ST_SIGN = 32'h1;
    localparam int ST_HALF_POS = 32'h2;
    localparam int ST_HALF_NEG = 32'h3;
    localparam int ST_OVF = 32'h4;
    localparam int ST_UNF = 32'h5;
    localparam int EN_HI_WAVE = 32'h0;
    localparam int WAV_RATE_LSB = 32'h3;
    localparam logic [2:0] WAV_SRC_POWER = 3'h1;
    // reset values
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] DIV_RST = 8'h00;
    // arithmetic
    localparam int GAIN_SHIFT = 32'hc;
    localparam logic signed [13:0] GAIN_ONE = 14'sh1000;
    localparam int OFS_SHIFT = 32'h8;
    localparam logic signed [47:0] PWR_FS = 48'sh0000_0ccc_cd00;
    localparam logic signed [47:0] PPM_1 = 48'sh96;
    localparam logic signed [47:0] PPM_2 = 48'sh4b;
    localparam logic signed [47:0] PPM_3 = 48'sh25;
    localparam logic signed [47:0] PPM_DEN = 48'sh0f_4240;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [23:0] wdata;
    } aea_req_s;

    typedef struct packed {
        logic [7:0] wav_sel;
        logic [7:0] nl_cfg;
        logic [7:0] acc_cfg;
        logic [7:0] en_lo;
        logic [7:0] en_hi;
        logic [7:0] sts_lo;
        logic [7:0] div;
        logic [11:0] gain;
        logic [15:0] ofs;
        logic [48:0] acc;
        logic [2:0] phase;
        logic prev_neg;
        logic [15:0] wav_cnt;
        logic [23:0] wav_data;
        logic wav_valid;
        logic [23:0] rdata;
        logic irq;
    } aea_state_s;
endpackage : aea_pkg

// ### bench/aea_core_model.sv
// core-side register master model for the energy block
`timescale 1ns/1ps
`default_nettype none
module aea_core_model
    import aea_pkg::*;
(
    // clock
    input wire logic i_mclk,
    // register port
    output var aea_req_s o_req,
    input wire logic [23:0] i_rdata
);
    initial begin
        o_req = '0;
    end
    // one request per call; address and data are scrambled once released
    task automatic xfer(input logic w, input logic [7:0] a, input logic [23:0] d);
        @(posedge i_mclk);
        o_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge i_mclk);
        o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : xfer
    task automatic rd(input logic [7:0] a, output logic [23:0] q);
        xfer(1'b0, a, 24'h0);
        @(posedge i_mclk);
        #1 q = i_rdata;
    endtask : rd
endmodule : aea_core_model
`default_nettype wire

// ### bench/aea_active_energy_tb.sv
// self-checking bench for the active energy accumulator
`timescale 1ns/1ps
`default_nettype none
module aea_active_energy_tb
    import aea_pkg::*;
;
    localparam int BASE = 8;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic signed [23:0] pwr = 24'h0;
    aea_req_s req;
    logic [23:0] rdata;
    logic [23:0] wdat;
    logic irq;
    logic wval;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h0001_1880;
    longint acc_exp = 0;
    longint gain = 0;
    longint ofs = 0;
    logic [1:0] code = 2'h0;
    logic [7:0] div = 8'h0;
    logic [7:0] regs [11] = '{ADDR_WAV_SEL, ADDR_NL_CFG, ADDR_ACC_CFG, ADDR_EN_LO, ADDR_EN_HI,
        ADDR_STS_LO, ADDR_DIV, ADDR_GAIN, ADDR_OFS, ADDR_ENERGY, 8'h55};

    aea_active_energy #(.WAV_BASE_CYC(BASE)) u_aea_active_energy (.i_mclk(i_mclk),
        .i_rst_n(i_rst_n), .i_ce(1'b1), .i_power(pwr), .i_req(req), .o_reg_rdata(rdata),
        .o_irq(irq), .o_wave_data(wdat), .o_wave_valid(wval));
    aea_core_model u_aea_core_model (.i_mclk(i_mclk), .o_req(req), .i_rdata(rdata));

    initial begin
        forever #12.5 i_mclk = ~i_mclk;
    end
    // the whole run needs well under this many cycles
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares++;
            results();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic longint thr();
        return (code == 2'h1 ? PPM_1 : code == 2'h2 ? PPM_2 : PPM_3) * PWR_FS / PPM_DEN;
    endfunction : thr
    function automatic longint gained(longint p);
        return (((p <<< 8) + ofs) * (64'sh1000 + gain)) >>> 12;
    endfunction : gained
    function automatic longint add_of(longint p, logic [1:0] m);
        longint g;
        g = gained(p);
        if (code != 2'h0 && (g < 0 ? -g : g) < thr()) return 0;
        g = g / (div == 8'h0 ? 64'sh1 : longint'(div));
        if (m[0] && g < 0) return 0;
        return (m[1] && g < 0) ? -g : g;
    endfunction : add_of

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        u_aea_core_model.xfer(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [23:0] e);
        logic [23:0] q;
        u_aea_core_model.rd(a, q);
        chk(q, e);
    endtask : rdc
    // the last of the n edges is the one at which the next call changes power
    task automatic hold(input longint p, input int n);
        @(posedge i_mclk);
        pwr <= p[23:0];
        repeat (n - 1) @(posedge i_mclk);
    endtask : hold
    task automatic flags(input logic [7:0] e);
        rdc(ADDR_STS_LO, {16'h0, e});
        chk({23'h0, irq}, {23'h0, e != 8'h0});
        wr(ADDR_STS_LO, 24'h3f);
    endtask : flags
    task automatic wait_valid(output int n);
        n = 0;
        do begin
            @(posedge i_mclk);
            #1 n++;
        end while (wval !== 1'b1 && n < 200);
    endtask : wait_valid
    task automatic results();
        if (miscompares == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    initial begin
        logic [23:0] q;
        logic [1:0] mode;
        int k;
        int n;
        longint p;
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        wr(ADDR_ENERGY, 24'hff_ffff);
        wr(8'h55, 24'hff_ffff);
        foreach (regs[j]) rdc(regs[j], 24'h0);
        for (int i = 0; i < 40; i++) begin
            mode = rnd();
            code = rnd();
            div = (i % 5 == 0) ? rnd() : rnd() & 32'h3;
            q = rnd();
            gain = q[0] ? longint'($signed(q[12:1])) : 0;
            q = rnd();
            p = $signed(q);
            // odd passes with no-load on sit right at the no-load threshold before gain
            if (i % 2 == 1 && code != 2'h0) p = ((thr() >>> 8) + q[1:0] - 1) * (q[2] ? -1 : 1);
            k = 1 + int'(rnd() & 32'h3);
            wr(ADDR_ACC_CFG, {22'h0, mode});
            wr(ADDR_NL_CFG, {22'h0, code});
            wr(ADDR_DIV, {16'h0, div});
            wr(ADDR_GAIN, {12'h0, gain[11:0]});
            hold(p, 5 * k);
            hold(0, 1);
            acc_exp += k * add_of(p, mode);
            rdc(ADDR_ENERGY, acc_exp[48:25]);
            rdc(ADDR_ENERGY_RC, acc_exp[48:25]);
            acc_exp &= 64'h1ff_ffff;
            rdc(ADDR_ENERGY, acc_exp[48:25]);
        end
        wr(ADDR_GAIN, 24'h0);
        wr(ADDR_NL_CFG, 24'h1);
        wr(ADDR_EN_LO, 24'h3);
        for (int d = 0; d < 2; d++) begin
            wr(ADDR_ACC_CFG, {21'h0, d[0], 2'h1});
            hold(64'sh10_0000, 10);
            wr(ADDR_STS_LO, 24'h3f);
            hold(64'sh10_0000, 10);
            flags(8'h0);
            hold(-64'sh10_0000, 10);
            flags(d == 0 ? 8'h2 : 8'h0);
            hold(64'sh10_0000, 10);
            flags(d == 1 ? 8'h2 : 8'h0);
            hold(64'sh1, 10);
            flags(8'h1);
        end
        q = rnd();
        gain = $signed(q[11:0]);
        ofs = $signed(q[23:12]);
        wr(ADDR_GAIN, {12'h0, gain[11:0]});
        wr(ADDR_OFS, {8'h0, ofs[15:0]});
        wr(ADDR_EN_HI, 24'h1);
        p = $signed(q[19:0]);
        hold(p, 2);
        for (int r = 0; r < 4; r++) begin
            wr(ADDR_WAV_SEL, {19'h0, r[1:0], 3'h1});
            wait_valid(n);
            wait_valid(n);
            wait_valid(n);
            chk(24'(n), 24'(BASE << r));
            acc_exp = gained(p);
            chk(wdat, acc_exp[31:8]);
        end
        wr(ADDR_EN_HI, 24'h0);
        hold(p, 5);
        wait_valid(n);
        chk(24'(n), 24'hc8);
        results();
    end
endmodule : aea_active_energy_tb
`default_nettype wire
